// ===== hw/tmr8c_pkg.sv
`default_nettype none
package tmr8c_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] OFS_OUTPUT_MODE = 3'h0;
  localparam logic [2:0] OFS_FORCE_MODE = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_COMPARE_A = 3'h3;
  localparam logic [2:0] OFS_COMPARE_B = 3'h4;
  localparam logic [2:0] OFS_FLAGS = 3'h5;

  // Output mode control fields
  localparam int CHAN_A_MODE_HI = 7;
  localparam int CHAN_A_MODE_LO = 6;
  localparam int CHAN_B_MODE_HI = 5;
  localparam int CHAN_B_MODE_LO = 4;
  localparam int WAVE_SEL_HI = 1;
  localparam int WAVE_SEL_LO = 0;
  // Force mode control fields
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WAVE_HIGH_BIT = 3;
  // Flag register fields
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;

  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Output mode encodings
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  // Waveform mode values
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_MAX = 3'h1;
  localparam logic [2:0] WM_CLR_CMP = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_RSVD_4 = 3'h4;
  localparam logic [2:0] WM_PHASE_CMP = 3'h5;
  localparam logic [2:0] WM_RSVD_6 = 3'h6;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;

  typedef enum logic [1:0] {
    TMR8C_KIND_NORMAL,
    TMR8C_KIND_CLR,
    TMR8C_KIND_FAST,
    TMR8C_KIND_PHASE
  } tmr8c_kind_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr8c_bus_type;

  typedef struct packed {
    logic [1:0][1:0] out_mode;
    logic [1:0] wave_lo;
    logic wave_hi;
    logic [7:0] count;
    logic count_down;
    logic match_block;
    logic [1:0][7:0] compare;
    logic [1:0][7:0] compare_buf;
    logic [1:0] wave;
    logic [2:0] flags;
    logic [7:0] rdata;
  } tmr8c_state_type;
endpackage : tmr8c_pkg
`default_nettype wire

// ===== hw/tmr8c_top.sv
// Functional notes
// R1 - Nonzero output mode hands pin to waveform
// R2 - Software sets pin direction before driving
// R3 - Non-PWM: off, toggle, clear, set on match
// R4 - PWM channel A 01 toggles only with high bit
// R5 - Fast PWM: 10 non-inverting, 11 inverting
// R6 - Phase correct: clear up, set down for 10
// R7 - Fast PWM compare at top acts at bottom
// R8 - Phase correct compare at top acts at top
// R9 - Output mode register bits 3:2 read zero
// R10 - Three-bit waveform mode selects kind and top
// R11 - Compare update immediate, at top, or bottom
// R12 - Overflow flag timing depends on mode
// R13 - Force strobes act only in non-PWM modes
// R14 - Software writes force zero during PWM
// R15 - Force applies match using current mode
// R16 - Force sets no flag, never clears counter
// R17 - Force bits and bits 5:4 read zero
// R18 - Fast PWM counts to top, then zero
// R19 - Phase correct counts up then down
// R20 - Reset clears all mode fields
//
// Design decisions made here: the strobed register port and the register offsets.
`default_nettype none
module tmr8c_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic timer_tick,
  input wire tmr8c_pkg::tmr8c_bus_type bus_req,
  output logic [7:0] reg_rdata,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_drive_a,
  output logic wave_drive_b,
  output logic overflow_flag
);
  import tmr8c_pkg::*;

  tmr8c_state_type s;
  tmr8c_state_type next_s;
  logic [2:0] waveform_mode_sel;
  tmr8c_kind_type kind;
  logic top_is_compare;
  logic [7:0] top;
  logic at_top;
  logic wrap_event;
  logic peak_event;
  logic bottom_event;
  logic ovf_event;
  logic [1:0] hit;
  logic [1:0] force_hit;
  logic [1:0] ignore_hit;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic wr_force;

  assign waveform_mode_sel = {s.wave_hi, s.wave_lo};

  always_comb begin
    kind = TMR8C_KIND_NORMAL;
    top_is_compare = 1'b0;
    // Reserved modes count as normal so the counter never stalls
    case (waveform_mode_sel) // [R10]
      WM_NORMAL: begin
        kind = TMR8C_KIND_NORMAL;
      end
      WM_PHASE_MAX: begin
        kind = TMR8C_KIND_PHASE;
      end
      WM_CLR_CMP: begin
        kind = TMR8C_KIND_CLR;
        top_is_compare = 1'b1;
      end
      WM_FAST_MAX: begin
        kind = TMR8C_KIND_FAST;
      end
      WM_PHASE_CMP: begin
        kind = TMR8C_KIND_PHASE;
        top_is_compare = 1'b1;
      end
      WM_FAST_CMP: begin
        kind = TMR8C_KIND_FAST;
        top_is_compare = 1'b1;
      end
      default: begin
        kind = TMR8C_KIND_NORMAL;
      end
    endcase
  end

  assign top = top_is_compare ? s.compare[0] : COUNT_MAX; // [R10]
  assign at_top = s.count == top;
  assign wrap_event = timer_tick && at_top;
  assign peak_event = timer_tick && at_top && !s.count_down;
  assign bottom_event = timer_tick && s.count_down &&
    (s.count == COUNT_BOTTOM);
  assign wr_force = bus_req.wr && (bus_req.addr == OFS_FORCE_MODE);

  always_comb begin
    ovf_event = 1'b0;
    case (waveform_mode_sel) // [R12]
      WM_PHASE_MAX, WM_PHASE_CMP: begin
        ovf_event = bottom_event;
      end
      WM_FAST_CMP: begin
        ovf_event = wrap_event;
      end
      default: begin
        ovf_event = timer_tick && (s.count == COUNT_MAX);
      end
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.rdata = RESET_BYTE;
    hit = 2'b00;
    force_hit = 2'b00;
    ignore_hit = 2'b00;
    flag_set = 3'b000;
    flag_clr = 3'b000;

    // Counter sequence
    if (timer_tick) begin
      next_s.match_block = 1'b0;
      case (kind)
        TMR8C_KIND_FAST: begin
          next_s.count = at_top ? COUNT_BOTTOM : s.count + 8'h01; // [R18]
        end
        TMR8C_KIND_PHASE: begin
          if (!s.count_down) begin // [R19]
            if (at_top) begin
              next_s.count_down = 1'b1;
              next_s.count = s.count - 8'h01;
            end else begin
              next_s.count = s.count + 8'h01;
            end
          end else if (s.count == COUNT_BOTTOM) begin
            next_s.count_down = 1'b0;
            next_s.count = s.count + 8'h01;
          end else begin
            next_s.count = s.count - 8'h01;
          end
        end
        TMR8C_KIND_CLR: begin
          next_s.count = at_top ? COUNT_BOTTOM : s.count + 8'h01;
        end
        default: begin
          next_s.count = s.count + 8'h01;
        end
      endcase
    end
    if (kind != TMR8C_KIND_PHASE) begin
      next_s.count_down = 1'b0;
    end

    // Per channel waveform
    for (int ch = 0; ch < 2; ch++) begin
      hit[ch] = timer_tick && !s.match_block &&
        (s.count == s.compare[ch]);
      force_hit[ch] = wr_force &&
        bus_req.wdata[FORCE_A_BIT - ch] &&
        (kind == TMR8C_KIND_NORMAL || kind == TMR8C_KIND_CLR); // [R13]
      ignore_hit[ch] = s.out_mode[ch][1] && (s.compare[ch] == top);
      case (kind)
        TMR8C_KIND_FAST: begin
          if (wrap_event && s.out_mode[ch][1]) begin // [R5] [R7]
            next_s.wave[ch] = (s.out_mode[ch] == OM_CLEAR);
          end else if (hit[ch] && !ignore_hit[ch]) begin
            case (s.out_mode[ch])
              OM_TOGGLE: begin
                if (ch == 0 && s.wave_hi) begin // [R4]
                  next_s.wave[ch] = !s.wave[ch];
                end
              end
              OM_CLEAR: begin
                next_s.wave[ch] = 1'b0; // [R5]
              end
              OM_SET: begin
                next_s.wave[ch] = 1'b1;
              end
              default: begin
                next_s.wave[ch] = s.wave[ch];
              end
            endcase
          end
        end
        TMR8C_KIND_PHASE: begin
          if (peak_event && ignore_hit[ch]) begin // [R8]
            next_s.wave[ch] = (s.out_mode[ch] == OM_CLEAR);
          end else if (hit[ch] && !ignore_hit[ch]) begin
            case (s.out_mode[ch])
              OM_TOGGLE: begin
                if (ch == 0 && s.wave_hi) begin // [R4]
                  next_s.wave[ch] = !s.wave[ch];
                end
              end
              OM_CLEAR: begin
                next_s.wave[ch] = s.count_down; // [R6]
              end
              OM_SET: begin
                next_s.wave[ch] = !s.count_down;
              end
              default: begin
                next_s.wave[ch] = s.wave[ch];
              end
            endcase
          end
        end
        default: begin
          // Force uses the mode field as it stands now
          if (hit[ch] || force_hit[ch]) begin // [R3] [R15]
            case (s.out_mode[ch])
              OM_TOGGLE: begin
                next_s.wave[ch] = !s.wave[ch];
              end
              OM_CLEAR: begin
                next_s.wave[ch] = 1'b0;
              end
              OM_SET: begin
                next_s.wave[ch] = 1'b1;
              end
              default: begin
                next_s.wave[ch] = s.wave[ch];
              end
            endcase
          end
        end
      endcase

      // Double buffered compare values
      case (kind) // [R11]
        TMR8C_KIND_FAST: begin
          if (wrap_event) begin
            next_s.compare[ch] = s.compare_buf[ch];
          end
        end
        TMR8C_KIND_PHASE: begin
          if (peak_event) begin
            next_s.compare[ch] = s.compare_buf[ch];
          end
        end
        default: begin
          next_s.compare[ch] = s.compare_buf[ch];
        end
      endcase
    end

    // Only genuine matches raise the match flags; a force never does
    flag_set[FLAG_MATCH_A] = hit[0]; // [R16]
    flag_set[FLAG_MATCH_B] = hit[1];
    flag_set[FLAG_OVERFLOW] = ovf_event;

    // Register writes win over the counter's own step
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_OUTPUT_MODE: begin
          next_s.out_mode[0] =
            bus_req.wdata[CHAN_A_MODE_HI:CHAN_A_MODE_LO];
          next_s.out_mode[1] =
            bus_req.wdata[CHAN_B_MODE_HI:CHAN_B_MODE_LO];
          next_s.wave_lo = bus_req.wdata[WAVE_SEL_HI:WAVE_SEL_LO];
        end
        OFS_FORCE_MODE: begin
          next_s.wave_hi = bus_req.wdata[WAVE_HIGH_BIT];
        end
        OFS_COUNT: begin
          // Next tick's match is suppressed after a count write
          next_s.count = bus_req.wdata;
          next_s.match_block = 1'b1;
        end
        OFS_COMPARE_A: begin
          next_s.compare_buf[0] = bus_req.wdata;
          if (kind == TMR8C_KIND_NORMAL || kind == TMR8C_KIND_CLR) begin
            next_s.compare[0] = bus_req.wdata; // [R11]
          end
        end
        OFS_COMPARE_B: begin
          next_s.compare_buf[1] = bus_req.wdata;
          if (kind == TMR8C_KIND_NORMAL || kind == TMR8C_KIND_CLR) begin
            next_s.compare[1] = bus_req.wdata; // [R11]
          end
        end
        OFS_FLAGS: begin
          flag_clr = bus_req.wdata[2:0];
        end
        default: begin
          flag_clr = 3'b000;
        end
      endcase
    end
    // Set wins over a same-cycle clear
    next_s.flags = (s.flags & ~flag_clr) | flag_set;

    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_OUTPUT_MODE: begin
          next_s.rdata = {s.out_mode[0], s.out_mode[1], 2'b00,
            s.wave_lo}; // [R9]
        end
        OFS_FORCE_MODE: begin
          next_s.rdata = {4'h0, s.wave_hi, 3'h0}; // [R17]
        end
        OFS_COUNT: begin
          next_s.rdata = s.count;
        end
        OFS_COMPARE_A: begin
          next_s.rdata = s.compare_buf[0];
        end
        OFS_COMPARE_B: begin
          next_s.rdata = s.compare_buf[1];
        end
        OFS_FLAGS: begin
          next_s.rdata = {5'h00, s.flags};
        end
        default: begin
          next_s.rdata = RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0; // [R20]
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign wave_out_a = s.wave[0];
  assign wave_out_b = s.wave[1];
  // Port direction bit stays outside this block
  assign wave_drive_a = s.out_mode[0] != OM_OFF && // [R1] [R2] [R4]
    !(s.out_mode[0] == OM_TOGGLE && !s.wave_hi &&
    (kind == TMR8C_KIND_FAST || kind == TMR8C_KIND_PHASE));
  assign wave_drive_b = s.out_mode[1] != OM_OFF; // [R1]
  assign overflow_flag = s.flags[FLAG_OVERFLOW];
endmodule : tmr8c_top
`default_nettype wire

// ===== bench/tmr8c_props.sv
`default_nettype none
module tmr8c_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic timer_tick,
  input wire tmr8c_pkg::tmr8c_bus_type bus_req,
  input wire logic [7:0] reg_rdata,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic wave_drive_a,
  input wire logic wave_drive_b,
  input wire logic overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr8c_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Mode high bit as last written, for the channel A toggle code
  logic hi_bit;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hi_bit <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == OFS_FORCE_MODE) begin
      hi_bit <= bus_req.wdata[WAVE_HIGH_BIT];
    end
  end
  sequence s_rd(logic [2:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence s_wr(logic [2:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  a_rdata_idle: assert property (!bus_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_rsvd_zero: assert property (s_rd(OFS_OUTPUT_MODE)
    |=> reg_rdata[3:2] == 2'h0) else $error("reserved bits set");
  a_force_zero: assert property (s_rd(OFS_FORCE_MODE)
    |=> reg_rdata[7:4] == 4'h0) else $error("force bits set");
  a_drive_a: assert property (s_wr(OFS_OUTPUT_MODE)
    |=> wave_drive_a == (|$past(bus_req.wdata[7:6]) &&
      !($past(bus_req.wdata[7:6]) == 2'h1 && $past(bus_req.wdata[0]) &&
      !$past(hi_bit)))) else $error("drive a wrong");
  a_drive_b: assert property (s_wr(OFS_OUTPUT_MODE)
    |=> wave_drive_b == (|$past(bus_req.wdata[5:4])))
    else $error("drive b wrong");
  a_drive_holds: assert property (!(bus_req.wr &&
    (bus_req.addr == OFS_OUTPUT_MODE || bus_req.addr == OFS_FORCE_MODE))
    |=> $stable({wave_drive_a, wave_drive_b})) else $error("drive moved");
  // Wave outputs and the overflow flag move only on a count step or a register write
  a_wave_holds: assert property (!timer_tick && !bus_req.wr
    |=> $stable({wave_out_a, wave_out_b})) else $error("wave moved");
  a_flag_holds: assert property (!timer_tick && !bus_req.wr
    |=> $stable(overflow_flag)) else $error("flag moved");
  a_flag_clear: assert property (s_wr(OFS_FLAGS)
    ##0 bus_req.wdata[0] && !timer_tick |=> !overflow_flag)
    else $error("flag not cleared");
endmodule : tmr8c_props
`default_nettype wire

// ===== bench/tb_tmr8c_top.sv
`default_nettype none
module tb_tmr8c_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr8c_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic timer_tick = 1'b0;
  tmr8c_bus_type bus_req = '0;
  logic [7:0] reg_rdata;
  logic wave_out_a, wave_out_b, wave_drive_a, wave_drive_b, overflow_flag;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [1:0] fcode [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
  logic fexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #12.5 mclk = ~mclk;
  tmr8c_top tmr8c_top_i (.mclk, .reset, .timer_tick, .bus_req, .reg_rdata,
    .wave_out_a, .wave_out_b, .wave_drive_a, .wave_drive_b, .overflow_flag);
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk8
  task chk1(input string s, input logic e, input logic g);
    chk8(s, {7'h0, e}, {7'h0, g});
  endtask : chk1
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_req <= {a, v, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr
  task rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 chk8("register", e, reg_rdata);
  endtask : rdc
  task run(input int n);
    @(posedge mclk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge mclk);
    timer_tick <= 1'b0;
    #1;
  endtask : run
  task rst;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
  endtask : rst
  // Ceiling well above the longest run of steps
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    rst;
    rdc(OFS_OUTPUT_MODE, 8'h00);
    rdc(OFS_FORCE_MODE, 8'h00);
    chk1("drive a", 1'b0, wave_drive_a);
    wr(OFS_OUTPUT_MODE, 8'hff);
    wr(OFS_FORCE_MODE, 8'hff);
    rdc(OFS_OUTPUT_MODE, 8'hf3);
    rdc(OFS_FORCE_MODE, 8'h08);
    chk1("drive b", 1'b1, wave_drive_b);
    chk1("wave a", 1'b0, wave_out_a);
    wr(3'h7, 8'h55);
    rdc(3'h7, 8'h00);
    $display("test registers done");
    rst;
    foreach (fcode[i]) begin
      wr(OFS_OUTPUT_MODE, {fcode[i], fcode[i], 4'h0});
      wr(OFS_FORCE_MODE, 8'hc0);
      chk1("wave a", fexp[i], wave_out_a);
      chk1("wave b", fexp[i], wave_out_b);
    end
    chk1("ovf", 1'b0, overflow_flag);
    wr(OFS_OUTPUT_MODE, 8'h00);
    chk1("drive a", 1'b0, wave_drive_a);
    wr(OFS_OUTPUT_MODE, 8'hf3);
    wr(OFS_FORCE_MODE, 8'hc0);
    chk1("wave a", 1'b0, wave_out_a);
    $display("test force done");
    rst;
    wr(OFS_COMPARE_A, 8'hfe);
    wr(OFS_OUTPUT_MODE, 8'h40);
    wr(OFS_COUNT, 8'hfd);
    run(2);
    chk1("wave a", 1'b1, wave_out_a);
    chk1("ovf", 1'b0, overflow_flag);
    run(1);
    chk1("ovf", 1'b1, overflow_flag);
    rdc(OFS_FLAGS, 8'h03);
    wr(OFS_FLAGS, 8'h07);
    rdc(OFS_FLAGS, 8'h00);
    $display("test normal done");
    rst;
    wr(OFS_COMPARE_A, 8'h03);
    wr(OFS_OUTPUT_MODE, 8'h42);
    wr(OFS_FORCE_MODE, 8'h80);
    chk1("wave a", 1'b1, wave_out_a);
    rdc(OFS_FLAGS, 8'h00);
    run(4);
    chk1("wave a", 1'b0, wave_out_a);
    rdc(OFS_COUNT, 8'h00);
    $display("test clear on compare done");
    rst;
    wr(OFS_OUTPUT_MODE, 8'he3);
    wr(OFS_COMPARE_A, 8'h05);
    wr(OFS_COMPARE_B, 8'h05);
    rdc(OFS_COMPARE_B, 8'h05);
    run(3);
    chk1("wave a", 1'b1, wave_out_a);
    run(253);
    chk1("wave a", 1'b0, wave_out_a);
    chk1("wave b", 1'b1, wave_out_b);
    chk1("ovf", 1'b1, overflow_flag);
    run(6);
    chk1("wave a", 1'b1, wave_out_a);
    chk1("wave b", 1'b0, wave_out_b);
    $display("test fast done");
    rst;
    wr(OFS_COMPARE_A, 8'h02);
    wr(OFS_OUTPUT_MODE, 8'hc1);
    run(3);
    chk1("wave a", 1'b1, wave_out_a);
    run(505);
    chk1("wave a", 1'b1, wave_out_a);
    run(1);
    chk1("wave a", 1'b0, wave_out_a);
    chk1("ovf", 1'b0, overflow_flag);
    run(2);
    chk1("ovf", 1'b1, overflow_flag);
    $display("test phase done");
    rst;
    wr(OFS_COMPARE_A, 8'hff);
    wr(OFS_OUTPUT_MODE, 8'h83);
    wr(OFS_COUNT, 8'hfe);
    run(2);
    chk1("wave a", 1'b1, wave_out_a);
    rst;
    wr(OFS_COMPARE_A, 8'hff);
    wr(OFS_OUTPUT_MODE, 8'h81);
    wr(OFS_COUNT, 8'hfe);
    run(2);
    chk1("wave a", 1'b1, wave_out_a);
    rst;
    wr(OFS_COMPARE_A, 8'h02);
    wr(OFS_OUTPUT_MODE, 8'h41);
    chk1("drive a", 1'b0, wave_drive_a);
    run(3);
    chk1("wave a", 1'b0, wave_out_a);
    wr(OFS_FORCE_MODE, 8'h08);
    chk1("drive a", 1'b1, wave_drive_a);
    wr(OFS_COUNT, 8'h00);
    run(3);
    chk1("wave a", 1'b1, wave_out_a);
    $display("test pwm edge done");
    close_out;
  end
endmodule : tb_tmr8c_top
bind tmr8c_top tmr8c_props tmr8c_props_i (.mclk, .reset, .timer_tick,
  .bus_req, .reg_rdata, .wave_out_a, .wave_out_b, .wave_drive_a,
  .wave_drive_b, .overflow_flag);
`default_nettype wire
